// File: common/smcp_pkg.sv
// Package: constants shared by the serial message command port.
// Assumes a 100 MHz device clock; baud rate is a parameter of the top.
package smcp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 57_600;
  localparam int CHAR_BITS = 10;
  localparam int DATA_BITS = 7;
  localparam int MAX_MSG_LEN = 255;
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_SEMI = 7'h3b;
  localparam logic [6:0] CH_QMARK = 7'h3f;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam int KEY_LEN = 16;
  localparam int RESP_LEN = 32;
  typedef enum logic [1:0] {SMCP_RX_IDLE, SMCP_RX_DATA, SMCP_RX_DONE} smcp_rx_e;
  typedef enum logic [1:0] {SMCP_TX_IDLE, SMCP_TX_CHAR, SMCP_TX_WAIT} smcp_tx_e;
  // Odd parity bit over seven data bits
  function automatic logic odd_par(input logic [6:0] d);
    odd_par = ~(^d);
  endfunction
endpackage

// File: hdl/smcp_uart_rx.sv
// Receiver: one 10-bit character frame (start, 7 data, odd parity, stop).
// Assumes rx_i is synchronous to clk_i and idles high.
`timescale 1ns/1ps
module smcp_uart_rx #(
  parameter int BIT_CYC = 1736
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial line
  input wire logic rx_i,
  // Character out
  output logic valid_o,
  output logic [6:0] data_o,
  output logic err_o
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);

  smcp_pkg::smcp_rx_e state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [8:0] sh, next_sh;
  logic next_valid, next_err;
  logic [6:0] next_data;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_valid = 1'b0;
    next_err = err_o;
    next_data = data_o;
    case (state)
      smcp_pkg::SMCP_RX_IDLE: begin
        if (!rx_i) begin
          next_state = smcp_pkg::SMCP_RX_DATA;
          next_cnt = HALF;
          next_bitn = 4'h0;
        end
      end
      smcp_pkg::SMCP_RX_DATA: begin
        if (cnt != '0) begin
          next_cnt = cnt - CW'(1);
        end else begin
          next_cnt = FULL;
          if (bitn == 4'h0 && rx_i) begin
            next_state = smcp_pkg::SMCP_RX_IDLE;
          end else if (bitn == 4'(smcp_pkg::CHAR_BITS - 1)) begin
            // Stop bit sampled: check frame and parity
            next_valid = 1'b1;
            // Eight shifts leave d0..d6 in sh[7:1] and parity in sh[8]
            next_data = sh[7:1];
            next_err = !rx_i || (sh[8] != smcp_pkg::odd_par(sh[7:1]));
            next_state = smcp_pkg::SMCP_RX_DONE;
          end else begin
            if (bitn != 4'h0) begin
              next_sh = {rx_i, sh[8:1]};
            end
            next_bitn = bitn + 4'h1;
          end
        end
      end
      smcp_pkg::SMCP_RX_DONE: begin
        if (rx_i) begin
          next_state = smcp_pkg::SMCP_RX_IDLE;
        end
      end
      default: next_state = smcp_pkg::SMCP_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= smcp_pkg::SMCP_RX_IDLE;
      cnt <= '0;
      bitn <= 4'h0;
      sh <= 9'h000;
      valid_o <= 1'b0;
      err_o <= 1'b0;
      data_o <= 7'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      valid_o <= next_valid;
      err_o <= next_err;
      data_o <= next_data;
    end
  end
endmodule

// File: hdl/smcp_port.sv
// Serial message command port: receives, splits and classifies host strings
// and transmits the reply to the last query. Assumes the instrument side
// supplies reply text on request and consumes command strings as they close.
`timescale 1ns/1ps
module smcp_port #(
  parameter int BAUD = smcp_pkg::BAUD_DEFAULT,
  parameter int KEY_LEN = smcp_pkg::KEY_LEN,
  parameter int RESP_LEN = smcp_pkg::RESP_LEN
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial line
  input wire logic rx_i,
  output logic tx_o,
  // Parsed strings toward the instrument
  output logic str_valid_o,
  output logic str_is_query_o,
  output logic [8*KEY_LEN-1:0] str_text_o,
  output logic [7:0] str_len_o,
  output logic overflow_o,
  // Reply text from the instrument
  output logic resp_req_o,
  input wire logic resp_valid_i,
  input wire logic [8*RESP_LEN-1:0] resp_text_i,
  input wire logic [7:0] resp_len_i
);
  localparam int BIT_CYC = smcp_pkg::CLK_HZ / BAUD;
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [7:0] MAXLEN = 8'(smcp_pkg::MAX_MSG_LEN);

  logic rx_valid, rx_err;
  logic [6:0] rx_data;

  smcp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rx_i(rx_i),
    .valid_o(rx_valid),
    .data_o(rx_data),
    .err_o(rx_err)
  );

  // Parser state
  logic [8*KEY_LEN-1:0] buf_q, next_buf;
  logic [7:0] len, next_len, total, next_total;
  logic bad, next_bad, qmark, next_qmark, pend_q, next_pend_q;
  logic next_str_valid, next_str_is_query, next_overflow, next_req;
  logic [8*KEY_LEN-1:0] next_str_text;
  logic [7:0] next_str_len;
  logic fire;

  always_comb begin
    next_buf = buf_q;
    next_len = len;
    next_total = total;
    next_bad = bad;
    next_qmark = qmark;
    next_pend_q = pend_q;
    next_str_valid = 1'b0;
    next_str_is_query = str_is_query_o;
    next_str_text = str_text_o;
    next_str_len = str_len_o;
    next_overflow = overflow_o;
    next_req = 1'b0;
    if (rx_valid) begin
      if (rx_err) begin
        next_bad = 1'b1;
      end
      if (total != MAXLEN) begin
        next_total = total + 8'h01;
      end else begin
        next_overflow = 1'b1;
      end
      if (rx_data == smcp_pkg::CH_LF || rx_data == smcp_pkg::CH_SEMI) begin
        // Close current string
        if (!next_bad && len != 8'h00) begin
          next_str_valid = 1'b1;
          next_str_is_query = qmark;
          next_str_text = buf_q;
          next_str_len = len;
          if (qmark) begin
            next_pend_q = 1'b1; // Later query replaces earlier
          end
        end
        next_len = 8'h00;
        next_buf = '0;
        next_qmark = 1'b0;
        if (rx_data == smcp_pkg::CH_LF) begin
          next_bad = 1'b0;
          next_total = 8'h00;
          next_overflow = 1'b0;
          next_req = pend_q || (next_str_valid && qmark);
          next_pend_q = 1'b0;
        end
      end else if (!rx_err) begin
        // Spaces are kept in the string like any character; question mark marks a query
        if (rx_data == smcp_pkg::CH_QMARK && !qmark) begin
          next_qmark = 1'b1;
        end
        if (len < 8'(KEY_LEN)) begin
          next_buf = {buf_q[8*KEY_LEN-9:0], 1'b0, rx_data};
        end
        if (len != 8'hff) begin
          next_len = len + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      buf_q <= '0;
      len <= 8'h00;
      total <= 8'h00;
      bad <= 1'b0;
      qmark <= 1'b0;
      pend_q <= 1'b0;
      str_valid_o <= 1'b0;
      str_is_query_o <= 1'b0;
      str_text_o <= '0;
      str_len_o <= 8'h00;
      overflow_o <= 1'b0;
      fire <= 1'b0;
    end else begin
      buf_q <= next_buf;
      len <= next_len;
      total <= next_total;
      bad <= next_bad;
      qmark <= next_qmark;
      pend_q <= next_pend_q;
      str_valid_o <= next_str_valid;
      str_is_query_o <= next_str_is_query;
      str_text_o <= next_str_text;
      str_len_o <= next_str_len;
      overflow_o <= next_overflow;
      fire <= next_req;
    end
  end

  // Transmitter: only started by a completed query
  smcp_pkg::smcp_tx_e tstate, next_tstate;
  logic [8*RESP_LEN-1:0] rbuf, next_rbuf;
  logic [7:0] rleft, next_rleft;
  logic [CW-1:0] tcnt, next_tcnt;
  logic [3:0] tbit, next_tbit;
  logic [9:0] tsh, next_tsh;
  logic next_tx;
  logic [6:0] ch;
  // Terminator already queued; the shifted frame cannot tell
  logic term, next_term;

  assign resp_req_o = (tstate == smcp_pkg::SMCP_TX_WAIT);

  always_comb begin
    next_tstate = tstate;
    next_rbuf = rbuf;
    next_rleft = rleft;
    next_tcnt = tcnt;
    next_tbit = tbit;
    next_tsh = tsh;
    next_tx = tx_o;
    next_term = term;
    ch = rbuf[8*RESP_LEN-2 -: 7];
    case (tstate)
      smcp_pkg::SMCP_TX_IDLE: begin
        next_tx = 1'b1;
        if (fire) begin
          next_tstate = smcp_pkg::SMCP_TX_WAIT;
        end
      end
      smcp_pkg::SMCP_TX_WAIT: begin
        if (resp_valid_i) begin
          next_rbuf = resp_text_i;
          next_rleft = (resp_len_i > 8'(RESP_LEN)) ? 8'(RESP_LEN) : resp_len_i;
          next_tbit = 4'(smcp_pkg::CHAR_BITS);
          next_tcnt = '0;
          next_term = 1'b0;
          next_tstate = smcp_pkg::SMCP_TX_CHAR;
        end
      end
      smcp_pkg::SMCP_TX_CHAR: begin
        if (tcnt != '0) begin
          next_tcnt = tcnt - CW'(1);
        end else if (tbit != 4'(smcp_pkg::CHAR_BITS)) begin
          next_tx = tsh[0];
          next_tsh = {1'b1, tsh[9:1]};
          next_tbit = tbit + 4'h1;
          next_tcnt = FULL;
        end else if (rleft != 8'h00) begin
          // Load next text character
          next_tsh = {1'b1, smcp_pkg::odd_par(ch), ch, 1'b0};
          next_rbuf = {rbuf[8*RESP_LEN-9:0], 8'h00};
          next_rleft = rleft - 8'h01;
          next_tbit = 4'h0;
        end else if (!term) begin
          // Terminator closes the reply, sent once
          next_tsh = {1'b1, smcp_pkg::odd_par(smcp_pkg::CH_LF), smcp_pkg::CH_LF, 1'b0};
          next_tbit = 4'h0;
          next_term = 1'b1;
        end else begin
          next_tstate = smcp_pkg::SMCP_TX_IDLE;
        end
      end
      default: next_tstate = smcp_pkg::SMCP_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tstate <= smcp_pkg::SMCP_TX_IDLE;
      rbuf <= '0;
      rleft <= 8'h00;
      tcnt <= '0;
      tbit <= 4'h0;
      tsh <= 10'h3ff;
      term <= 1'b0;
      tx_o <= 1'b1;
    end else begin
      tstate <= next_tstate;
      rbuf <= next_rbuf;
      rleft <= next_rleft;
      tcnt <= next_tcnt;
      tbit <= next_tbit;
      tsh <= next_tsh;
      term <= next_term;
      tx_o <= next_tx;
    end
  end
endmodule

// File: tb/smcp_port_chk.sv
// Checker: pin timing of the serial message command port.
// Assumes bind onto smcp_port with ten or more clocks per bit.
`timescale 1ns/1ps
module smcp_port_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched pins
  input wire logic tx_o,
  input wire logic str_valid_o,
  input wire logic str_is_query_o,
  input wire logic [7:0] str_len_o,
  input wire logic overflow_o,
  input wire logic resp_req_o,
  input wire logic resp_valid_i
);
  // Query presented since the last reply request
  logic q_seen;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_seen <= 1'b0;
    end else if (str_valid_o && str_is_query_o) begin
      q_seen <= 1'b1;
    end else if (resp_req_o) begin
      q_seen <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_start;
    ##3 $fell(tx_o);
  endsequence
  sequence s_low;
    !tx_o [*8];
  endsequence
  property p_rst;
    disable iff (1'b0) sys_rst_i |=> tx_o && !str_valid_o && !overflow_o && !resp_req_o;
  endproperty
  property p_pulse;
    str_valid_o |=> !str_valid_o;
  endproperty
  property p_len;
    str_valid_o |-> str_len_o != 8'h00;
  endproperty
  property p_req_src;
    $rose(resp_req_o) |-> q_seen;
  endproperty
  property p_req_cmd;
    str_valid_o && !str_is_query_o && !q_seen |=> !$rose(resp_req_o);
  endproperty
  property p_req_hold;
    resp_req_o && !resp_valid_i |=> resp_req_o;
  endproperty
  property p_tx_go;
    resp_req_o && resp_valid_i |-> s_start;
  endproperty
  property p_bit;
    $fell(tx_o) |-> s_low;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  a_pulse: assert property (p_pulse) else $error("string strobe too long");
  a_len: assert property (p_len) else $error("empty string presented");
  a_req_src: assert property (p_req_src) else $error("reply asked without query");
  a_req_cmd: assert property (p_req_cmd) else $error("command asked a reply");
  a_req_hold: assert property (p_req_hold) else $error("reply request dropped");
  a_tx_go: assert property (p_tx_go) else $error("reply start late");
  a_bit: assert property (p_bit) else $error("low bit too short");
endmodule

// File: tb/smcp_host.sv
// Host model: sends framed strings and collects reply characters.
// Assumes BC clocks per bit; tasks are entered at a falling edge.
`timescale 1ns/1ps
module smcp_host #(
  parameter int BC = 10,
  parameter int GAP = 800
) (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic tx_i,
  output logic rx_o
);
  logic [6:0] rxq[$];
  int perr = 0;
  initial rx_o = 1'b1;
  task automatic put(input logic [6:0] c, input bit bad);
    logic [9:0] f;
    f = {1'b1, ~(^c) ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o = f[i];
      repeat (BC) @(negedge clk_i);
    end
  endtask
  // One unbroken string, then the quiet pause
  task automatic msg(input logic [6:0] m[$], input int bad_at);
    for (int i = 0; i < m.size(); i++) put(m[i], i == bad_at);
    put(7'h0a, 1'b0);
    repeat (GAP) @(negedge clk_i);
  endtask
  always begin
    logic [9:0] f;
    @(negedge tx_i);
    repeat (BC / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = tx_i;
      if (i < 9) repeat (BC) @(posedge clk_i);
    end
    if (f[0] || !f[9] || !(^f[8:1])) perr++;
    rxq.push_back(f[7:1]);
  end
endmodule

// File: tb/smcp_port_bench.sv
// Bench: host model on the serial side, instrument answers reply requests.
// Assumes BAUD of ten million, so ten clocks per bit.
`timescale 1ns/1ps
module smcp_port_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rx_i, tx_o, str_valid_o, str_is_query_o, overflow_o, resp_req_o;
  logic [127:0] str_text_o;
  logic [7:0] str_len_o;
  logic resp_valid_i = 1'b0;
  logic [6:0] r0 = 7'h61;
  logic [6:0] r1 = 7'h62;
  logic [255:0] resp_text_i;
  logic [16:0] st = 17'h00000;
  logic ovf = 1'b0;
  int nstr = 0, nreq = 0, miscompares = 0, checked = 0;
  assign resp_text_i = {1'b0, r0, 1'b0, r1, 240'h0};
  initial forever #5 clk_i = ~clk_i;
  smcp_host h (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
  smcp_port #(.BAUD(10_000_000)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_i(rx_i),
    .tx_o(tx_o), .str_valid_o(str_valid_o), .str_is_query_o(str_is_query_o),
    .str_text_o(str_text_o), .str_len_o(str_len_o), .overflow_o(overflow_o),
    .resp_req_o(resp_req_o), .resp_valid_i(resp_valid_i), .resp_text_i(resp_text_i),
    .resp_len_i(8'h02));
  always @(negedge clk_i) resp_valid_i <= (resp_req_o === 1'b1) && !resp_valid_i;
  always @(posedge clk_i) begin
    if (str_valid_o === 1'b1) begin
      nstr <= nstr + 1;
      st <= {str_is_query_o, str_len_o, str_text_o[7:0]};
    end
    if (resp_req_o === 1'b1 && resp_valid_i === 1'b1) nreq <= nreq + 1;
    if (overflow_o === 1'b1) ovf <= 1'b1;
  end
  function automatic logic [16:0] exp_st(input bit q, input int n, input logic [6:0] c);
    return {q, 8'(n > 255 ? 255 : n), 1'b0, c};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rx(input int n);
    int k = 0;
    while (h.rxq.size() < n) begin
      k++;
      if (k > 3000) begin
        miscompares++;
        tally_and_finish();
      end
      @(negedge clk_i);
    end
  endtask
  initial begin
    logic [6:0] m[$];
    r0 = 7'h61 + 7'($urandom(32'hce94b564) % 26);
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    h.msg('{7'h41, 7'h42, 7'h20, 7'h35}, -1);
    chk(st, exp_st(0, 4, 7'h35));
    chk(str_text_o[31:0], 32'h41422035);
    chk(nstr, 1);
    chk(nreq + h.rxq.size(), 0);
    $display("command test done");
    r1 = 7'h61 + 7'($urandom % 26);
    h.msg('{7'h58, 7'h3f, 7'h3b, 7'h59, 7'h3f, 7'h20, 7'h31}, -1);
    wait_rx(3);
    repeat (800) @(negedge clk_i);
    chk(nstr, 3);
    chk(st, exp_st(1, 4, 7'h31));
    chk(nreq, 1);
    chk(h.rxq.size(), 3);
    chk({h.rxq[0], h.rxq[1], h.rxq[2]}, {r0, r1, 7'h0a});
    chk(h.perr, 0);
    h.rxq.delete();
    $display("chained query test done");
    h.msg('{7'h41, 7'h20, 7'h31, 7'h3b, 7'h42, 7'h3f}, 2);
    chk(nstr, 3);
    chk(nreq + h.rxq.size(), 1);
    $display("bad parity test done");
    for (int t = 0; t < 4; t++) begin
      m = {};
      repeat (1 + $urandom % 5) m.push_back(7'h41 + 7'($urandom % 26));
      h.msg(m, -1);
      chk(st, exp_st(0, m.size(), m[$]));
    end
    chk(nstr, 7);
    $display("random command test done");
    m = {};
    repeat (256) m.push_back(7'h41);
    h.msg(m, -1);
    chk(ovf, 1);
    chk(overflow_o, 0);
    chk(st, exp_st(0, 256, 7'h41));
    $display("overflow test done");
    tally_and_finish();
  end
endmodule
bind smcp_port smcp_port_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_o(tx_o),
  .str_valid_o(str_valid_o), .str_is_query_o(str_is_query_o), .str_len_o(str_len_o),
  .overflow_o(overflow_o), .resp_req_o(resp_req_o), .resp_valid_i(resp_valid_i));
